// File: logic/hamming_codec.sv
`timescale 1ns/1ps
`default_nettype none
module hamming_codec (
    input wire logic [storage_ecc_pkg::PAYLOAD_W-1:0] payload,
    input wire logic [storage_ecc_pkg::CHECK_W-1:0] check_in,
    output logic [storage_ecc_pkg::CHECK_W-1:0] check_out,
    output logic single_err,
    output logic double_err,
    output logic [storage_ecc_pkg::PAYLOAD_W-1:0] fixed
);
    import storage_ecc_pkg::*;

    // code position of payload bit i, skipping the power-of-two slots
    function automatic int bit_pos(input int i);
        int count;
        int found;
        count = 0;
        found = 0;
        for (int p = 3; p < HAM_SPAN; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (count == i && found == 0) begin
                    found = p;
                end
                count = count + 1;
            end
        end
        return found;
    endfunction

    function automatic logic [PAYLOAD_W-1:0] cover_mask(input int k);
        logic [PAYLOAD_W-1:0] m;
        m = '0;
        for (int i = 0; i < PAYLOAD_W; i++) begin
            m[i] = ((bit_pos(i) >> k) & 1) != 0;
        end
        return m;
    endfunction

    logic [HAM_W-1:0] ham_bits;
    logic [HAM_W-1:0] syndrome;
    logic overall_err;

    genvar k;
    genvar i;
    generate
        for (k = 0; k < HAM_W; k++) begin : g_check
            assign ham_bits[k] = ^(payload & cover_mask(k));
        end
        for (i = 0; i < PAYLOAD_W; i++) begin : g_fix
            localparam logic [HAM_W-1:0] POS = HAM_W'(bit_pos(i));
            assign fixed[i] = payload[i] ^ (single_err && syndrome == POS);
        end
    endgenerate

    assign check_out = {^{payload, ham_bits}, ham_bits};
    assign syndrome = ham_bits ^ check_in[HAM_W-1:0];
    assign overall_err = ^{payload, check_in};
    assign single_err = overall_err;
    assign double_err = !overall_err && syndrome != '0;
endmodule
`default_nettype wire

// File: logic/storage_ecc_pkg.sv
// What this block does
// - normal storage corrects single, detects double errors
// - selected arrays only detect, never correct
// - system storage codes cover data and address
// - peripheral storage codes cover data only
// - all-zeros or all-ones word is illegal on data-only coded arrays
// - nonvolatile array accepts all-ones erased word
// - data-only coverage reports all-x as uncorrectable
// - address coverage gives all-x no dedicated check
// - every single and double error reaches collector
// - graphics correction mode sacrifices capacity for check bits
// - processor caches carry no code at all
package storage_ecc_pkg;

    localparam int DATA_W = 32;
    localparam int INDEX_W = 4;
    localparam int DEPTH = 16;
    // graphics array words left usable once check bits take their share
    localparam logic [INDEX_W-1:0] GFX_ECC_LIMIT = 4'hE;
    localparam int ADDR_COVER_W = 8;
    localparam int PAYLOAD_W = DATA_W + ADDR_COVER_W;
    localparam int HAM_W = 6;
    localparam int CHECK_W = HAM_W + 1;
    localparam int HAM_SPAN = 64;
    localparam logic [CHECK_W-1:0] CHECK_RESET = 7'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

    typedef enum logic [2:0] {
        KIND_SYSTEM,
        KIND_PERIPHERAL,
        KIND_DETECT,
        KIND_CACHE,
        KIND_GRAPHICS,
        KIND_NONVOLATILE
    } mem_kind_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic raw;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0] wdata;
        logic [CHECK_W-1:0] raw_check;
    } req_type;

    typedef struct packed {
        logic valid;
        logic was_write;
        logic range_err;
        logic corrected;
        logic uncorrectable;
        logic [DATA_W-1:0] rdata;
        logic [CHECK_W-1:0] rcheck;
    } rsp_type;

    typedef struct packed {
        logic correctable;
        logic uncorrectable;
    } fault_type;

endpackage

// File: logic/storage_ecc_protection.sv
`timescale 1ns/1ps
`default_nettype none
module storage_ecc_protection (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire storage_ecc_pkg::mem_kind_type kind,
    input wire logic gfx_correct_en,
    input wire storage_ecc_pkg::req_type req,
    output storage_ecc_pkg::rsp_type rsp,
    output storage_ecc_pkg::fault_type fault
);
    import storage_ecc_pkg::*;

    logic [DATA_W-1:0] mem_data_q [DEPTH];
    logic [CHECK_W-1:0] mem_check_q [DEPTH];
    rsp_type rsp_q;
    rsp_type rsp_d;
    fault_type fault_q;
    fault_type fault_d;

    // kind decoding
    wire gfx_coded = kind == KIND_GRAPHICS && gfx_correct_en;
    // caches and uncoded graphics neither generate nor check a code
    wire code_on = !(kind == KIND_CACHE) && !(kind == KIND_GRAPHICS && !gfx_correct_en);
    wire correct_on = code_on && kind != KIND_DETECT;
    wire addr_cover = kind == KIND_SYSTEM;
    wire erased_ok = kind == KIND_NONVOLATILE;
    // check bits occupy the top of the graphics array when coding is on
    wire in_range = !(gfx_coded && req.index >= GFX_ECC_LIMIT);

    // encode path
    wire [ADDR_COVER_W-1:0] addr_field = addr_cover ? ADDR_COVER_W'(req.index) : '0;
    wire [PAYLOAD_W-1:0] wr_payload = {addr_field, req.wdata};
    logic [CHECK_W-1:0] wr_check_gen;
    wire [CHECK_W-1:0] wr_check = req.raw ? req.raw_check
                                  : (code_on ? wr_check_gen : CHECK_RESET);
    wire do_write = req.valid && req.write && in_range;

    hamming_codec enc (
        .payload(wr_payload),
        .check_in(CHECK_RESET),
        .check_out(wr_check_gen),
        .single_err(),
        .double_err(),
        .fixed()
    );

    // decode path, same index as the request
    wire [DATA_W-1:0] rd_word = mem_data_q[req.index];
    wire [CHECK_W-1:0] rd_check = mem_check_q[req.index];
    wire [PAYLOAD_W-1:0] rd_payload = {addr_field, rd_word};
    logic [PAYLOAD_W-1:0] rd_fixed;
    logic rd_single;
    logic rd_double;

    hamming_codec dec (
        .payload(rd_payload),
        .check_in(rd_check),
        .check_out(),
        .single_err(rd_single),
        .double_err(rd_double),
        .fixed(rd_fixed)
    );

    // all-x words: data and check bits together
    wire all_zero = {rd_word, rd_check} == '0;
    wire all_one = &{rd_word, rd_check};
    // with address coverage all-x content only meets the syndrome
    wire erased = erased_ok && all_one;
    wire allx_bad = code_on && !addr_cover && !erased && (all_zero || all_one);
    wire raw_err = code_on && !erased && (rd_single || rd_double);

    wire rd_uncorr = allx_bad || (raw_err && (!correct_on || rd_double));
    wire rd_corr = !allx_bad && raw_err && correct_on && rd_single;
    wire do_read = req.valid && !req.write;
    wire rd_good = do_read && in_range;

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = req.valid;
        rsp_d.was_write = req.write;
        rsp_d.range_err = req.valid && !in_range;
        if (rd_good) begin
            rsp_d.corrected = rd_corr;
            rsp_d.uncorrectable = rd_uncorr;
            // corrected word goes back with the flag
            rsp_d.rdata = rd_corr ? rd_fixed[DATA_W-1:0] : rd_word;
            rsp_d.rcheck = rd_check;
        end
    end

    always_comb begin
        fault_d = '0;
        fault_d.correctable = rd_good && rd_corr;
        fault_d.uncorrectable = rd_good && rd_uncorr;
    end

    genvar w;
    generate
        for (w = 0; w < DEPTH; w++) begin : g_word
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_data_q[w] <= DATA_RESET;
                    mem_check_q[w] <= CHECK_RESET;
                end else if (do_write && req.index == INDEX_W'(w)) begin
                    mem_data_q[w] <= req.wdata;
                    mem_check_q[w] <= wr_check;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_q <= '0;
            fault_q <= '0;
        end else begin
            rsp_q <= rsp_d;
            fault_q <= fault_d;
        end
    end

    assign rsp = rsp_q;
    assign fault = fault_q;
endmodule
`default_nettype wire

// File: test/fault_collector_model.sv
`timescale 1ns/1ps
`default_nettype none
module fault_collector_model (
    input wire logic sys_clk,
    input wire storage_ecc_pkg::fault_type fault,
    output int n_corr,
    output int n_unc
);
    import storage_ecc_pkg::*;
    initial n_corr = 0;
    initial n_unc = 0;
    // counts survive resets so the bench can total a whole run
    always @(posedge sys_clk) begin
        n_corr <= n_corr + int'(fault.correctable === 1'b1);
        n_unc <= n_unc + int'(fault.uncorrectable === 1'b1);
    end
endmodule
`default_nettype wire

// File: test/storage_ecc_protection_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module storage_ecc_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire storage_ecc_pkg::mem_kind_type kind,
    input wire logic gfx_correct_en,
    input wire storage_ecc_pkg::req_type req,
    input wire storage_ecc_pkg::rsp_type rsp,
    input wire storage_ecc_pkg::fault_type fault
);
    import storage_ecc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic rd_rsp = rsp.valid && !rsp.was_write;
    wire logic [38:0] word = {rsp.rdata, rsp.rcheck};
    AST_LATENCY: assert property (req.valid |=> rsp.valid)
        else $error("no response one cycle after request");
    AST_FAULT_PAIR: assert property (rd_rsp |-> fault == {rsp.corrected, rsp.uncorrectable})
        else $error("fault pulse differs from read status");
    AST_FAULT_CAUSE: assert property (fault != '0 |-> rd_rsp)
        else $error("fault pulse without read response");
    AST_ONE_CLASS: assert property (rsp.valid |-> !(rsp.corrected && rsp.uncorrectable))
        else $error("read both corrected and uncorrectable");
    AST_DETECT_ONLY: assert property (rsp.valid && kind == KIND_DETECT |-> !rsp.corrected)
        else $error("detect-only array corrected a word");
    AST_CACHE_BARE: assert property (kind == KIND_CACHE |-> fault == '0)
        else $error("uncoded cache raised a fault");
    AST_GFX_PLAIN: assert property (kind == KIND_GRAPHICS && !gfx_correct_en |-> fault == '0)
        else $error("graphics array flagged with coding off");
    AST_GFX_RANGE: assert property (req.valid && kind == KIND_GRAPHICS && gfx_correct_en
        && req.index >= 4'hE |=> rsp.range_err && rsp.rdata == '0 && fault == '0)
        else $error("graphics check-bit area still reachable");
    AST_ALLX_DATA: assert property (rd_rsp && kind == KIND_PERIPHERAL && (word == '0 || &word)
        |-> rsp.uncorrectable || rsp.corrected)
        else $error("all-zero or all-one word read clean");
    cover property (fault.correctable);
    cover property (fault.uncorrectable);
    cover property (rsp.range_err);
endmodule
bind storage_ecc_protection storage_ecc_checker checker_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .kind(kind), .gfx_correct_en(gfx_correct_en), .req(req), .rsp(rsp), .fault(fault));
`default_nettype wire

// File: test/storage_ecc_protection_tb.sv
`timescale 1ns/1ps
`default_nettype none
module storage_ecc_protection_tb;
    import storage_ecc_pkg::*;
    logic sys_clk = 0, rst_b = 0, gfx = 0;
    mem_kind_type kind = KIND_SYSTEM;
    req_type req = '0;
    rsp_type rsp;
    fault_type fault;
    int n_errors = 0, checks_done = 0, ec = 0, eu = 0, nc, nu;
    logic [38:0] q[$];
    logic [38:0] e;
    logic [31:0] lf = 28, d;
    logic [3:0] ix;
    logic [7:0] a;
    storage_ecc_protection storage_ecc_protection_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .kind(kind), .gfx_correct_en(gfx), .req(req), .rsp(rsp), .fault(fault));
    fault_collector_model fault_collector_model_i (.sys_clk(sys_clk), .fault(fault),
        .n_corr(nc), .n_unc(nu));
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [6:0] ecc(logic [39:0] pl);
        logic [5:0] h = '0;
        int p = 3;
        for (int i = 0; i < 40; i++) begin
            while ((p & (p - 1)) == 0) p++;
            for (int k = 0; k < 6; k++) if (p[k]) h[k] ^= pl[i];
            p++;
        end
        return {^pl ^ ^h, h};
    endfunction
    task automatic chk(string n, logic [38:0] s, logic [38:0] x);
        checks_done++;
        if (s !== x) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, x, s);
        end
    endtask
    // f = {range, corrected, uncorrectable}; dd is expected read data or written data
    task automatic op(logic w, logic r, logic [3:0] i, logic [31:0] dd, logic [6:0] c, logic [2:0] f);
        @(negedge sys_clk);
        req <= '{1'b1, w, r, i, dd, c};
        q.push_back({w, f, w ? 2'b00 : f[1:0], dd});
        ec += int'(!w && f[1]);
        eu += int'(!w && f[0]);
        @(negedge sys_clk);
        req.valid <= 1'b0;
    endtask
    task automatic rs(mem_kind_type k, logic en);
        @(negedge sys_clk);
        rst_b <= 0;
        kind <= k;
        gfx <= en;
        repeat (16) @(negedge sys_clk);
        rst_b <= 1;
    endtask
    always @(negedge sys_clk) if (rsp.valid === 1'b1) begin
        e = q.size() ? q.pop_front() : 'x;
        chk("response", {rsp.was_write, rsp.range_err, rsp.corrected, rsp.uncorrectable, fault,
            rsp.was_write ? e[31:0] : rsp.rdata}, e);
    end
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end
    initial begin
        rs(KIND_SYSTEM, 0);
        repeat (4) begin
            d = rnd();
            ix = d[35 % 32 +: 4];
            a = {4'h0, ix};
            op(1, 0, ix, d, 0, 0);
            op(0, 0, ix, d, 0, 0);
            op(1, 1, ix, d ^ (1 << d[4:0]), ecc({a, d}), 0);
            op(0, 0, ix, d, 0, 3'b010);
            op(1, 1, ix, d ^ 3, ecc({a, d}), 0);
            op(0, 0, ix, d ^ 3, 0, 3'b001);
            op(1, 1, ix, d, ecc({a ^ 8'h01, d}), 0);
            op(0, 0, ix, d, 0, 3'b010);
        end
        rs(KIND_PERIPHERAL, 0);
        op(0, 0, 4'h3, '0, 0, 3'b001);
        op(1, 1, 4'h3, '1, '1, 0);
        op(0, 0, 4'h3, '1, 0, 3'b001);
        d = rnd();
        op(1, 1, 4'h4, d ^ 32'h00000100, ecc({8'h00, d}), 0);
        op(0, 0, 4'h4, d, 0, 3'b010);
        rs(KIND_NONVOLATILE, 0);
        op(1, 1, 4'h7, '1, '1, 0);
        op(0, 0, 4'h7, '1, 0, 0);
        op(0, 0, 4'h8, '0, 0, 3'b001);
        rs(KIND_DETECT, 0);
        op(1, 1, 4'h2, d ^ 32'h00010000, ecc({8'h00, d}), 0);
        op(0, 0, 4'h2, d ^ 32'h00010000, 0, 3'b001);
        rs(KIND_CACHE, 0);
        op(1, 1, 4'h9, d, 7'h55, 0);
        op(0, 0, 4'h9, d, 0, 0);
        chk("rcheck", {32'h00000000, rsp.rcheck}, {32'h00000000, 7'h55});
        rs(KIND_GRAPHICS, 0);
        op(1, 1, 4'hF, d, 7'h2A, 0);
        op(0, 0, 4'hF, d, 0, 0);
        rs(KIND_GRAPHICS, 1);
        op(1, 0, 4'hD, d, 0, 0);
        op(0, 0, 4'hD, d, 0, 0);
        op(0, 0, 4'hE, '0, 0, 3'b100);
        op(0, 0, 4'hF, '0, 0, 3'b100);
        repeat (4) @(negedge sys_clk);
        chk("collector", {nc[18:0], nu[19:0]}, {ec[18:0], eu[19:0]});
        give_verdict();
    end
endmodule
`default_nettype wire
